//--- inc/tgu_pkg.sv
`default_nettype none
package tgu_pkg;
   // =====================================================================
   // register byte offsets
   localparam logic [4:0]  CS_OFS    = 5'h00;
   localparam logic [4:0]  CNT_OFS   = 5'h04;
   localparam logic [4:0]  TOVAL_OFS = 5'h08;
   localparam logic [4:0]  WIN_OFS   = 5'h0C;
   localparam logic [4:0]  STAT_OFS  = 5'h10;
   // =====================================================================
   // control/status field positions
   localparam int CS_W        = 12;
   localparam int CS_EN       = 0;
   localparam int CS_UPD      = 1;
   localparam int CS_IRQEN    = 2;
   localparam int CS_WINM     = 3;
   localparam int CS_SRC      = 4;
   localparam int CS_PRE      = 6;
   localparam int CS_WAIT     = 7;
   localparam int CS_STOP     = 8;
   localparam int CS_DBG      = 9;
   localparam int CS_TST      = 10;
   localparam int CS_OPEN     = 12;
   localparam int STAT_RUN    = 0;
   localparam int STAT_IRQ    = 1;
   // =====================================================================
   // reset values: enabled, update allowed, source 1, divide 1, runs in wait
   localparam logic [11:0] CS_RST    = 12'h093;
   localparam logic [15:0] TOVAL_RST = 16'hFFFF;
   localparam logic [15:0] WIN_RST   = 16'h0000;
   // =====================================================================
   // sequence keys (values arbitrary)
   localparam logic [31:0] UNLOCK_KEY1  = 32'h5A5A_1001;
   localparam logic [31:0] UNLOCK_KEY2  = 32'hA5A5_2002;
   localparam logic [31:0] REFRESH_KEY1 = 32'h3C3C_3003;
   localparam logic [31:0] REFRESH_KEY2 = 32'hC3C3_4004;
   // =====================================================================
   // timing counts: window and lead in mclk cycles, prescaler last value in source ticks
   localparam int          CFG_WIN_CYCLES  = 256;
   localparam int          IRQ_LEAD_CYCLES = 128;
   localparam logic [7:0]  PRE_LAST        = 8'hFF;
   // =====================================================================
   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_LEAD = 3'b010,
      ST_FIRE = 3'b100
   } tgu_state_type;
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b001,
      SQ_UNL1 = 3'b010,
      SQ_REF1 = 3'b100
   } tgu_seq_type;
   typedef enum logic [1:0] {
      TST_OFF  = 2'b00,
      TST_USER = 2'b01,
      TST_LOW  = 2'b10,
      TST_HIGH = 2'b11
   } tgu_test_type;
endpackage : tgu_pkg
`default_nettype wire

//--- hdl/tgu_tick_guard_unit.sv
// Operation
// [R1] control/status register takes one write per configuration window; later writes ignored
// [R2] write-once 16-bit expiry count of ticks sets when the watchdog expires
// [R3] write-once 16-bit refresh window value, used only when window mode enabled
// [R4] no valid refresh before counter reaches expiry count asserts the system reset
// [R5] only the ordered pair first then second refresh word counts as refresh
// [R6] reconfiguration needs the ordered two-word unlock pair first
// [R7] software masks its interrupts during unlock and configuration
// [R8] configuration writes only while window open and register not yet written
// [R9] reconfiguration after reset only if update-allow bit was set
// [R10] enable bit in control register starts or stops the watchdog
// [R11] two-bit source select picks one of four tick sources 0 to 3
// [R12] prescaler bit divides the chosen tick by 1 or by 256
// [R13] test field: off, user, low byte only, high byte only
// [R14] with interrupt enabled an interrupt precedes the forced reset
// [R15] interrupt enable lives in control register under write-once rules
// [R16] read-only running flag reads set while the watchdog is enabled
// [R17] interrupt flag sets on the interrupt and holds until software clears
// [R18] separate bits decide counting in wait, stop and debug modes
// [R19] current 16-bit counter value readable at any time
// [R20] software waits 4 low-power clock cycles after initial configuration
// [R21] valid refresh clears the counter to zero
// [R22] refresh in window mode below window value is a violation and resets
// [R23] broken sequences or writes to a closed window trigger the reset
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tgu_tick_guard_unit #(
   parameter int CFG_WIN_CYCLES  = tgu_pkg::CFG_WIN_CYCLES,
   parameter int IRQ_LEAD_CYCLES = tgu_pkg::IRQ_LEAD_CYCLES
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // tick sources, one-cycle pulses
   input  wire logic [3:0]  tick_src,
   // system power states
   input  wire logic        in_wait,
   input  wire logic        in_stop,
   input  wire logic        in_debug,
   // outcomes
   output logic             pre_reset_irq,
   output logic             system_reset_req
);
   // =====================================================================
   // parameter checks
   if (CFG_WIN_CYCLES < 1 || CFG_WIN_CYCLES > 65535) begin : g_bad_win
      $error("configuration window length out of range");
   end
   if (IRQ_LEAD_CYCLES < 1 || IRQ_LEAD_CYCLES > 65535) begin : g_bad_lead
      $error("interrupt lead length out of range");
   end

   localparam logic [15:0] WIN_LOAD  = 16'(CFG_WIN_CYCLES - 1);
   localparam logic [15:0] LEAD_LOAD = 16'(IRQ_LEAD_CYCLES - 1);

   // =====================================================================
   // functions
   function automatic logic [15:0] cnt_step(input logic [15:0] c,
                                            input logic [1:0]  t);
      logic [15:0] r;
      r = c + 16'h0001;
      if (t == tgu_pkg::TST_LOW) begin
         r = {c[15:8], 8'(c[7:0] + 8'h01)};
      end else if (t == tgu_pkg::TST_HIGH) begin
         r = {8'(c[15:8] + 8'h01), c[7:0]};
      end
      return r;
   endfunction : cnt_step

   function automatic logic cnt_hit(input logic [15:0] c,
                                    input logic [15:0] v,
                                    input logic [1:0]  t);
      logic r;
      r = (c >= v);
      if (t == tgu_pkg::TST_LOW) begin
         r = (c[7:0] >= v[7:0]);
      end else if (t == tgu_pkg::TST_HIGH) begin
         r = (c[15:8] >= v[15:8]);
      end
      return r;
   endfunction : cnt_hit

   // =====================================================================
   // state
   logic [11:0]            cs_r;
   logic [15:0]            toval_r;
   logic [15:0]            win_r;
   logic [15:0]            cnt_r;
   logic [7:0]             pre_cnt_r;
   logic [15:0]            wct_cnt_r;
   logic                   wct_open_r;
   logic                   cs_w_r;
   logic                   to_w_r;
   logic                   wi_w_r;
   logic                   irq_flag_r;
   logic                   irq_flag_nxt;
   logic [15:0]            lead_cnt_r;
   logic                   ack_r;
   logic [31:0]            dat_r;
   tgu_pkg::tgu_state_type state_r;
   tgu_pkg::tgu_state_type state_nxt;
   tgu_pkg::tgu_seq_type   seq_r;
   tgu_pkg::tgu_seq_type   seq_nxt;

   // =====================================================================
   // bus decode
   logic req;
   logic wr;
   logic rd;
   logic sel_cs;
   logic sel_cnt;
   logic sel_to;
   logic sel_wi;
   logic sel_st;

   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   // partial-word writes are dropped so a key can never be half written
   assign wr  = req & wb_we_i & (wb_sel_i == 4'hF);
   assign rd  = req & ~wb_we_i;

   always_comb begin
      sel_cs  = 1'b0;
      sel_cnt = 1'b0;
      sel_to  = 1'b0;
      sel_wi  = 1'b0;
      sel_st  = 1'b0;
      if (wb_adr_i == tgu_pkg::CS_OFS) begin
         sel_cs = 1'b1;
      end else if (wb_adr_i == tgu_pkg::CNT_OFS) begin
         sel_cnt = 1'b1;
      end else if (wb_adr_i == tgu_pkg::TOVAL_OFS) begin
         sel_to = 1'b1;
      end else if (wb_adr_i == tgu_pkg::WIN_OFS) begin
         sel_wi = 1'b1;
      end else if (wb_adr_i == tgu_pkg::STAT_OFS) begin
         sel_st = 1'b1;
      end
   end

   // =====================================================================
   // unlock and refresh sequences
   logic bad_seq;
   logic refresh_ok;
   logic refresh_early;
   logic unlock_ok;
   logic cfg_wr;
   logic cfg_closed;

   assign cfg_wr     = wr & (sel_cs | sel_to | sel_wi);
   assign cfg_closed = cfg_wr & ~wct_open_r;   // [R23]

   always_comb begin
      seq_nxt       = seq_r;
      bad_seq       = 1'b0;
      refresh_ok    = 1'b0;
      refresh_early = 1'b0;
      unlock_ok     = 1'b0;
      if (wr) begin
         case (seq_r)
            tgu_pkg::SQ_UNL1: begin
               seq_nxt = tgu_pkg::SQ_IDLE;
               if (sel_cnt && wb_dat_i == tgu_pkg::UNLOCK_KEY2) begin
                  // without update-allow the pair is accepted but opens nothing
                  unlock_ok = cs_r[tgu_pkg::CS_UPD];   // [R6] [R9]
               end else begin
                  bad_seq = 1'b1;   // [R23]
               end
            end
            tgu_pkg::SQ_REF1: begin
               seq_nxt = tgu_pkg::SQ_IDLE;
               if (sel_cnt && wb_dat_i == tgu_pkg::REFRESH_KEY2) begin
                  if (cs_r[tgu_pkg::CS_WINM] && cnt_r < win_r) begin
                     refresh_early = 1'b1;   // [R22]
                  end else begin
                     refresh_ok = 1'b1;   // [R5]
                  end
               end else begin
                  bad_seq = 1'b1;   // [R23]
               end
            end
            default: begin
               if (sel_cnt) begin
                  if (wb_dat_i == tgu_pkg::UNLOCK_KEY1) begin
                     seq_nxt = tgu_pkg::SQ_UNL1;
                  end else if (wb_dat_i == tgu_pkg::REFRESH_KEY1) begin
                     seq_nxt = tgu_pkg::SQ_REF1;
                  end else begin
                     bad_seq = 1'b1;   // [R23]
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         seq_r <= tgu_pkg::SQ_IDLE;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   // =====================================================================
   // configuration window: open after reset, reopened by a valid unlock
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wct_open_r <= 1'b1;
         wct_cnt_r  <= WIN_LOAD;
      end else if (unlock_ok) begin
         wct_open_r <= 1'b1;   // [R6]
         wct_cnt_r  <= WIN_LOAD;
      end else if (wct_open_r) begin
         if (wct_cnt_r == 16'h0000) begin
            wct_open_r <= 1'b0;   // [R8]
         end else begin
            wct_cnt_r <= wct_cnt_r - 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || unlock_ok) begin
         cs_w_r <= 1'b0;
         to_w_r <= 1'b0;
         wi_w_r <= 1'b0;
      end else if (wr && wct_open_r) begin
         cs_w_r <= cs_w_r | sel_cs;   // [R1] [R8]
         to_w_r <= to_w_r | sel_to;
         wi_w_r <= wi_w_r | sel_wi;
      end
   end

   // =====================================================================
   // write-once configuration registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cs_r <= tgu_pkg::CS_RST;
      end else if (wr && sel_cs && wct_open_r && !cs_w_r) begin
         // enable, irq enable, source, prescale, modes, test all land here
         cs_r <= wb_dat_i[11:0];   // [R1] [R10] [R11] [R12] [R13] [R15] [R18]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         toval_r <= tgu_pkg::TOVAL_RST;
      end else if (wr && sel_to && wct_open_r && !to_w_r) begin
         toval_r <= wb_dat_i[15:0];   // [R2]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         win_r <= tgu_pkg::WIN_RST;
      end else if (wr && sel_wi && wct_open_r && !wi_w_r) begin
         win_r <= wb_dat_i[15:0];   // [R3]
      end
   end

   // =====================================================================
   // tick path and counter
   logic src_tick;
   logic cnt_run;
   logic tick;
   logic timeout;

   assign src_tick = tick_src[cs_r[tgu_pkg::CS_SRC +: 2]];   // [R11]
   assign cnt_run  = cs_r[tgu_pkg::CS_EN] & (state_r == tgu_pkg::ST_RUN)
                   & (~in_wait  | cs_r[tgu_pkg::CS_WAIT])    // [R18]
                   & (~in_stop  | cs_r[tgu_pkg::CS_STOP])
                   & (~in_debug | cs_r[tgu_pkg::CS_DBG]);
   assign tick     = cnt_run & src_tick
                   & (~cs_r[tgu_pkg::CS_PRE] | (pre_cnt_r == tgu_pkg::PRE_LAST));   // [R12]
   assign timeout  = cnt_run & cnt_hit(cnt_r, toval_r, cs_r[tgu_pkg::CS_TST +: 2]);   // [R4]

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pre_cnt_r <= 8'h00;
      end else if (cnt_run && src_tick) begin
         pre_cnt_r <= pre_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || refresh_ok || !cs_r[tgu_pkg::CS_EN]) begin
         cnt_r <= 16'h0000;   // [R21] [R10]
      end else if (tick) begin
         cnt_r <= cnt_step(cnt_r, cs_r[tgu_pkg::CS_TST +: 2]);   // [R13]
      end
   end

   // =====================================================================
   // expiry sequence: optional interrupt lead, then reset until system reset
   logic trig;

   assign trig = timeout | bad_seq | cfg_closed | refresh_early;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         tgu_pkg::ST_RUN: begin
            if (trig) begin
               if (cs_r[tgu_pkg::CS_IRQEN]) begin
                  state_nxt = tgu_pkg::ST_LEAD;   // [R14]
               end else begin
                  state_nxt = tgu_pkg::ST_FIRE;   // [R4] [R22] [R23]
               end
            end
         end
         tgu_pkg::ST_LEAD: begin
            if (lead_cnt_r == 16'h0000) begin
               state_nxt = tgu_pkg::ST_FIRE;   // [R14]
            end
         end
         default: begin
            state_nxt = tgu_pkg::ST_FIRE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= tgu_pkg::ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || state_r != tgu_pkg::ST_LEAD) begin
         lead_cnt_r <= LEAD_LOAD;
      end else begin
         lead_cnt_r <= lead_cnt_r - 16'h0001;
      end
   end

   // set wins over a same-cycle clear
   always_comb begin
      irq_flag_nxt = irq_flag_r;
      if (wr && sel_st && wb_dat_i[tgu_pkg::STAT_IRQ]) begin
         irq_flag_nxt = 1'b0;
      end
      if (state_r == tgu_pkg::ST_RUN && state_nxt == tgu_pkg::ST_LEAD) begin
         irq_flag_nxt = 1'b1;   // [R17]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_flag_r <= 1'b0;
      end else begin
         irq_flag_r <= irq_flag_nxt;   // [R17]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pre_reset_irq    <= 1'b0;
         system_reset_req <= 1'b0;
      end else begin
         pre_reset_irq    <= irq_flag_nxt & cs_r[tgu_pkg::CS_IRQEN];   // [R14]
         system_reset_req <= (state_nxt == tgu_pkg::ST_FIRE);   // [R4]
      end
   end

   // =====================================================================
   // bus answer: ack one cycle after the request, unmapped reads return zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req;
         if (rd) begin
            dat_r <= 32'h0000_0000;
            if (sel_cs) begin
               dat_r[tgu_pkg::CS_W:0] <= {wct_open_r, cs_r};
            end else if (sel_cnt) begin
               dat_r[15:0] <= cnt_r;   // [R19]
            end else if (sel_to) begin
               dat_r[15:0] <= toval_r;
            end else if (sel_wi) begin
               dat_r[15:0] <= win_r;
            end else if (sel_st) begin
               dat_r[tgu_pkg::STAT_RUN] <= cs_r[tgu_pkg::CS_EN];   // [R16]
               dat_r[tgu_pkg::STAT_IRQ] <= irq_flag_r;
            end
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // =====================================================================
   // checks
   sequence s_unlock_pair;
      wr && sel_cnt && seq_r == tgu_pkg::SQ_UNL1 && wb_dat_i == tgu_pkg::UNLOCK_KEY2
         && cs_r[tgu_pkg::CS_UPD];
   endsequence

   sequence s_fire_now;
      state_r == tgu_pkg::ST_FIRE ##1 system_reset_req;
   endsequence

   chk_ack_single_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   chk_cs_write_once: assert property (@(posedge mclk) disable iff (!rst_n)   // [R1]
      (wr && sel_cs && cs_w_r) |=> $stable(cs_r))
      else $error("control register changed on a second write");

   chk_closed_window_hold: assert property (@(posedge mclk) disable iff (!rst_n)   // [R8]
      (wr && sel_to && !wct_open_r) |=> $stable(toval_r))
      else $error("expiry count written with window closed");

   chk_unlock_reopen: assert property (@(posedge mclk) disable iff (!rst_n)   // [R6]
      s_unlock_pair |=> wct_open_r && !cs_w_r && !to_w_r && !wi_w_r)
      else $error("unlock did not reopen the window");

   chk_refresh_clears_cnt: assert property (@(posedge mclk) disable iff (!rst_n)   // [R21]
      refresh_ok |=> cnt_r == 16'h0000)
      else $error("refresh did not clear the counter");

   chk_early_refresh_fires: assert property (@(posedge mclk) disable iff (!rst_n)   // [R22]
      (refresh_early && state_r == tgu_pkg::ST_RUN && !cs_r[tgu_pkg::CS_IRQEN])
         |=> s_fire_now)
      else $error("early refresh did not force reset");

   chk_closed_cfg_fires: assert property (@(posedge mclk) disable iff (!rst_n)   // [R23]
      (cfg_closed && state_r == tgu_pkg::ST_RUN && !cs_r[tgu_pkg::CS_IRQEN])
         |=> s_fire_now)
      else $error("closed-window write did not force reset");

   chk_irq_lead_reset: assert property (@(posedge mclk) disable iff (!rst_n)   // [R14]
      (state_r == tgu_pkg::ST_RUN && state_nxt == tgu_pkg::ST_LEAD)
         |=> pre_reset_irq && !system_reset_req ##[1:1000] system_reset_req)
      else $error("interrupt did not precede reset");

   chk_irq_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)   // [R17]
      (irq_flag_r && !(wr && sel_st && wb_dat_i[tgu_pkg::STAT_IRQ])) |=> irq_flag_r)
      else $error("interrupt flag dropped without clear");

   chk_running_flag: assert property (@(posedge mclk) disable iff (!rst_n)   // [R16]
      (rd && sel_st) |=> wb_dat_o[tgu_pkg::STAT_RUN] == $past(cs_r[tgu_pkg::CS_EN]))
      else $error("running flag does not follow enable");

   chk_cnt_readable: assert property (@(posedge mclk) disable iff (!rst_n)   // [R19]
      (rd && sel_cnt) |=> wb_dat_o[15:0] == $past(cnt_r))
      else $error("counter read mismatch");

   chk_stop_freeze: assert property (@(posedge mclk) disable iff (!rst_n)   // [R18]
      (in_stop && !cs_r[tgu_pkg::CS_STOP] && cs_r[tgu_pkg::CS_EN] && !refresh_ok)
         |=> $stable(cnt_r))
      else $error("counter moved in stop mode");

   chk_prescale_hold: assert property (@(posedge mclk) disable iff (!rst_n)   // [R12]
      (cs_r[tgu_pkg::CS_PRE] && cs_r[tgu_pkg::CS_EN] && pre_cnt_r != tgu_pkg::PRE_LAST
         && !refresh_ok) |=> $stable(cnt_r))
      else $error("counter advanced before 256 source ticks");

   chk_timeout_fires: assert property (@(posedge mclk) disable iff (!rst_n)   // [R4]
      (timeout && !cs_r[tgu_pkg::CS_IRQEN]) |=> s_fire_now)
      else $error("timeout did not force reset");

endmodule : tgu_tick_guard_unit
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // =====================================================================
   // stimulus, observation and reference model state
   logic        mclk, rst_n, cyc, stb, we;
   logic [4:0]  adr;
   logic [3:0]  sel, tick_src;
   logic [31:0] dat_i, dat_o, rd;
   logic        ack, irq, rreq, in_wait, in_stop, in_debug;
   logic [15:0] tov_m;
   logic [11:0] cs_m;
   logic [1:0]  src;
   logic [3:0]  hot;
   int          err_count, n_checks, cnt_m;

   tgu_tick_guard_unit #(.CFG_WIN_CYCLES(64), .IRQ_LEAD_CYCLES(16)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .tick_src(tick_src), .in_wait(in_wait), .in_stop(in_stop),
      .in_debug(in_debug), .pre_reset_irq(irq), .system_reset_req(rreq));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // =====================================================================
   // shared tasks
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk_bit

   // classic single cycle; the master never assumes a latency
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= d; sel <= 4'hF;
      for (i = 0; i < 20 && ack !== 1'b1; i++) begin
         @(posedge mclk);
      end
      if (ack !== 1'b1) begin
         err_count++;
         report_and_stop();
      end
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge mclk);
   endtask : bus

   // bounded wait for an outcome pin: 0 for the irq, 1 for the reset request
   task automatic wait_out(input logic which, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge mclk);
         if ((which ? rreq : irq) === 1'b1) return;
      end
      err_count++;
      report_and_stop();
   endtask : wait_out

   task automatic ticks(input int n, input logic [3:0] bits);
      repeat (n) begin
         @(posedge mclk);
         tick_src <= bits;
         @(posedge mclk);
         tick_src <= 4'h0;
      end
   endtask : ticks

   task automatic do_reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : do_reset

   // =====================================================================
   // main sequence
   initial begin
      rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 5'h00; sel = 4'h0;
      dat_i = 32'h0; tick_src = 4'h0; in_wait = 1'b0; in_stop = 1'b0; in_debug = 1'b0;
      err_count = 0; n_checks = 0;
      void'($urandom(32'h996931CB));
      do_reset();
      bus(1'b0, tgu_pkg::TOVAL_OFS, 32'h0); chk(rd, 32'h0000FFFF);
      bus(1'b0, tgu_pkg::WIN_OFS, 32'h0);   chk(rd, 32'h0);
      bus(1'b0, tgu_pkg::CS_OFS, 32'h0);    chk(rd & 32'hFFF, 32'h093);
      bus(1'b0, tgu_pkg::STAT_OFS, 32'h0);  chk(rd, 32'h1);
      bus(1'b0, 5'h14, 32'h0);              chk(rd, 32'h0);
      // configure: random source and expiry, second writes must not land
      src = 2'($urandom_range(3, 0));
      hot = 4'h1 << src;
      tov_m = 16'(20 + $urandom_range(10, 0));
      cs_m = 12'h087 | {6'h0, src, 4'h0};
      // unlock and configuration run back to back, nothing may come between
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::UNLOCK_KEY1);
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::UNLOCK_KEY2);
      bus(1'b1, tgu_pkg::TOVAL_OFS, {16'h0, tov_m});
      bus(1'b1, tgu_pkg::TOVAL_OFS, 32'h3);
      bus(1'b1, tgu_pkg::CS_OFS, {20'h0, cs_m});
      bus(1'b1, tgu_pkg::CS_OFS, 32'h0);
      repeat (4) @(posedge mclk);
      bus(1'b0, tgu_pkg::TOVAL_OFS, 32'h0); chk(rd, {16'h0, tov_m});
      bus(1'b0, tgu_pkg::CS_OFS, 32'h0);    chk(rd & 32'hFFF, {20'h0, cs_m});
      // only the selected source advances the counter
      cnt_m = 5 + $urandom_range(10, 0);
      ticks(cnt_m, hot);
      ticks(3, ~hot);
      bus(1'b0, tgu_pkg::CNT_OFS, 32'h0);   chk(rd, 32'(cnt_m));
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::REFRESH_KEY1);
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::REFRESH_KEY2);
      cnt_m = 0;
      bus(1'b0, tgu_pkg::CNT_OFS, 32'h0);   chk(rd, 32'(cnt_m));
      // expiry with the irq enabled: irq first, reset request later
      ticks(int'(tov_m), hot);
      wait_out(1'b0, 8);
      chk_bit(rreq, 1'b0);
      bus(1'b0, tgu_pkg::STAT_OFS, 32'h0);  chk(rd, 32'h3);
      bus(1'b1, tgu_pkg::STAT_OFS, 32'h2);
      bus(1'b0, tgu_pkg::STAT_OFS, 32'h0);  chk(rd, 32'h1);
      wait_out(1'b1, 40);
      chk_bit(rreq, 1'b1);
      // window mode, and the stop, debug and wait gates
      do_reset();
      cs_m = 12'h08B | {6'h0, src, 4'h0};
      bus(1'b1, tgu_pkg::WIN_OFS, 32'h8);
      bus(1'b1, tgu_pkg::TOVAL_OFS, 32'h30);
      bus(1'b1, tgu_pkg::CS_OFS, {20'h0, cs_m});
      bus(1'b0, tgu_pkg::WIN_OFS, 32'h0);   chk(rd, 32'h8);
      in_stop <= 1'b1;
      ticks(3, hot);
      in_stop <= 1'b0;
      in_debug <= 1'b1;
      ticks(3, hot);
      in_debug <= 1'b0;
      in_wait <= 1'b1;
      ticks(4, hot);
      in_wait <= 1'b0;
      bus(1'b0, tgu_pkg::CNT_OFS, 32'h0);   chk(rd, 32'h4);
      ticks(5, hot);
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::REFRESH_KEY1);
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::REFRESH_KEY2);
      bus(1'b0, tgu_pkg::CNT_OFS, 32'h0);   chk(rd, 32'h0);
      ticks(2, hot);
      chk_bit(rreq, 1'b0);
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::REFRESH_KEY1);
      bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::REFRESH_KEY2);
      wait_out(1'b1, 40);
      chk_bit(rreq, 1'b1);
      // divide by 256 with the low byte test: only the low byte is compared
      do_reset();
      cs_m = 12'h843 | {6'h0, src, 4'h0};
      bus(1'b1, tgu_pkg::TOVAL_OFS, 32'hFF02);
      bus(1'b1, tgu_pkg::CS_OFS, {20'h0, cs_m});
      ticks(256, hot);
      bus(1'b0, tgu_pkg::CNT_OFS, 32'h0);   chk(rd, 32'h1);
      ticks(256, hot);
      wait_out(1'b1, 8);
      chk_bit(rreq, 1'b1);
      // closed window write, then a broken refresh pair
      for (int k = 0; k < 2; k++) begin
         do_reset();
         if (k == 0) begin
            bus(1'b1, tgu_pkg::CS_OFS, 32'h2);
            bus(1'b0, tgu_pkg::STAT_OFS, 32'h0);  chk(rd, 32'h0);
            ticks(3, 4'hF);
            bus(1'b0, tgu_pkg::CNT_OFS, 32'h0);   chk(rd, 32'h0);
            repeat (80) @(posedge mclk);
            bus(1'b1, tgu_pkg::TOVAL_OFS, 32'h5);
         end else begin
            bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::REFRESH_KEY1);
            bus(1'b1, tgu_pkg::CNT_OFS, tgu_pkg::UNLOCK_KEY2);
         end
         wait_out(1'b1, 40);
         chk_bit(rreq, 1'b1);
      end
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
